/* File: upg_pkg.sv */
package upg_pkg;
	// Core clock period
	localparam int unsigned CLK_PS       = 20000;
	// Word-aligned register offsets
	localparam logic [9:0]  OFS_PERIOD_HI = 10'h1b4;
	localparam logic [9:0]  OFS_PERIOD_LO = 10'h1bc;
	localparam logic [9:0]  OFS_PULSE_CTL = 10'h1ec;
	// Divider step per sample mode
	localparam int unsigned STEP_REAL_PS  = 175000;
	localparam int unsigned STEP_CPLX_PS  = 171400;
	// Default epoch period
	localparam longint unsigned EPOCH_DEF_PS = 64'd50_000_000_000;
	localparam int unsigned EPOCH_DEF_REAL = int'(EPOCH_DEF_PS / STEP_REAL_PS);
	localparam int unsigned EPOCH_DEF_CPLX = int'(EPOCH_DEF_PS / STEP_CPLX_PS);
	// Pulse length: whole phase-clock cycles plus leftover phases of the master clock
	localparam longint unsigned REAL_MCLK_HZ = 64'd40_000_000;
	localparam longint unsigned REAL_PHASES  = 64'd7;
	localparam longint unsigned REAL_WHOLE   = 64'd5714;
	localparam longint unsigned REAL_FRAC    = 64'd2;
	localparam longint unsigned CPLX_MCLK_HZ = 64'd35_000_000;
	localparam longint unsigned CPLX_PHASES  = 64'd6;
	localparam longint unsigned CPLX_WHOLE   = 64'd5833;
	localparam longint unsigned CPLX_FRAC    = 64'd1;
	localparam longint unsigned PS_PER_S     = 64'd1_000_000_000_000;
	localparam longint unsigned PULSE_REAL_PS =
		(REAL_WHOLE * REAL_PHASES + REAL_FRAC) * PS_PER_S / REAL_MCLK_HZ;
	localparam longint unsigned PULSE_CPLX_PS =
		(CPLX_WHOLE * CPLX_PHASES + CPLX_FRAC) * PS_PER_S / CPLX_MCLK_HZ;
	localparam int unsigned PULSE_CYC_REAL = int'(PULSE_REAL_PS / CLK_PS);
	localparam int unsigned PULSE_CYC_CPLX = int'(PULSE_CPLX_PS / CLK_PS);
	// Field layouts
	localparam int unsigned HI_BITS      = 8;
	localparam int unsigned HI_ONCE_BIT  = 15;
	localparam int unsigned CTL_PER_BIT  = 15;
	localparam int unsigned CTL_PIN_BIT  = 14;
	localparam int unsigned CTL_N_BITS   = 8;
	localparam int unsigned PER_BITS     = 24;
	localparam int unsigned PLEN_BITS    = 16;
	localparam int unsigned ACC_BITS     = 19;
	// Reset values
	localparam logic [PER_BITS-1:0] PERIOD_RST = 24'h000000;

	typedef struct packed {
		logic        std_mode;
		logic [9:0]  addr;
		logic [15:0] wdata;
		logic        wr;
	} upg_host_s;
endpackage

/* File: upg_pulse_gen.sv */
`timescale 1ns/100ps
// Overview of operation
// - Pulse drives discrete output pin when enabled
// - Pulse starts on epoch strobe rising edge
// - Separate counter ends pulse after 1ms
// - Ratio change lasts one strobe period
// - Real mode divider steps every 175ns
// - Complex mode divider steps every 171.4ns
// - One-shot arms single pulse at next strobe
// - Periodic pulses next strobe, then every nth
// - Length 5714+2/7 or 5833+1/6 phase cycles
// - Strobe period defaults 50ms, register programmable
// - Measurement data latched at every strobe
module upg_pulse_gen #(
	parameter int unsigned PULSE_CYC_REAL = upg_pkg::PULSE_CYC_REAL,
	parameter int unsigned PULSE_CYC_CPLX = upg_pkg::PULSE_CYC_CPLX,
	parameter int unsigned EPOCH_DEF_REAL = upg_pkg::EPOCH_DEF_REAL,
	parameter int unsigned EPOCH_DEF_CPLX = upg_pkg::EPOCH_DEF_CPLX
) (
	input  wire logic              core_clk,
	input  wire logic              rst,
	input  wire upg_pkg::upg_host_s host,
	input  wire logic              complex_mode,
	input  wire logic [15:0]       meas_data,
	output logic                   meas_epoch_strobe,
	output logic [15:0]            meas_latched_q,
	output logic                   armed_q,
	output logic                   timemark_q,
	output logic                   timemark_pin
);
	localparam int unsigned PB = upg_pkg::PER_BITS;
	localparam int unsigned LB = upg_pkg::PLEN_BITS;
	localparam int unsigned AB = upg_pkg::ACC_BITS;
	localparam int unsigned NB = upg_pkg::CTL_N_BITS;

	// Register decode
	logic [7:0] word_idx;
	logic       wr_hi;
	logic       wr_lo;
	logic       wr_ctl;
	assign word_idx = host.std_mode ? host.addr[7:0] : host.addr[9:2];
	assign wr_hi    = host.wr && (word_idx == upg_pkg::OFS_PERIOD_HI[9:2]);
	assign wr_lo    = host.wr && (word_idx == upg_pkg::OFS_PERIOD_LO[9:2]);
	assign wr_ctl   = host.wr && (word_idx == upg_pkg::OFS_PULSE_CTL[9:2]);

	// Fractional divider step
	logic [AB-1:0] acc_q;
	logic [AB-1:0] acc_d;
	logic [AB-1:0] acc_sum;
	logic [AB-1:0] step;
	logic          tick;
	assign step    = complex_mode ? AB'(upg_pkg::STEP_CPLX_PS) : AB'(upg_pkg::STEP_REAL_PS);
	assign acc_sum = acc_q + AB'(upg_pkg::CLK_PS);
	assign tick    = acc_sum >= step;
	assign acc_d   = tick ? acc_sum - step : acc_sum;

	// Epoch divider
	logic [7:0]    hi_q;
	logic          hi_once_q;
	logic [PB-1:0] period_q;
	logic [PB-1:0] slew_q;
	logic          slew_pend_q;
	logic [PB-1:0] cnt_q;
	logic [PB-1:0] def_ratio;
	logic [PB-1:0] ratio;
	logic [PB-1:0] wr_value;
	logic          strobe;
	logic          at_end;
	assign def_ratio = complex_mode ? PB'(EPOCH_DEF_CPLX) : PB'(EPOCH_DEF_REAL);
	assign ratio     = slew_pend_q ? slew_q :
		(period_q == upg_pkg::PERIOD_RST) ? def_ratio : period_q;
	assign at_end    = (cnt_q + PB'(1)) >= ratio;
	assign strobe    = tick && at_end;
	assign wr_value  = {hi_q, host.wdata};

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			acc_q <= '0;
			cnt_q <= '0;
		end else begin
			acc_q <= acc_d;
			if (tick) begin
				cnt_q <= at_end ? '0 : cnt_q + PB'(1);
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			hi_q        <= '0;
			hi_once_q   <= 1'b0;
			period_q    <= upg_pkg::PERIOD_RST;
			slew_q      <= '0;
			slew_pend_q <= 1'b0;
		end else begin
			if (wr_hi) begin
				hi_q      <= host.wdata[7:0];
				hi_once_q <= host.wdata[upg_pkg::HI_ONCE_BIT];
			end
			// A new write wins over the strobe that ends a slewed period
			if (wr_lo && hi_once_q) begin
				slew_q      <= wr_value;
				slew_pend_q <= 1'b1;
			end else if (strobe) begin
				slew_pend_q <= 1'b0;
			end
			if (wr_lo && !hi_once_q) begin
				period_q <= wr_value;
			end
		end
	end

	// Measurement capture
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			meas_epoch_strobe <= 1'b0;
			meas_latched_q    <= '0;
		end else begin
			meas_epoch_strobe <= strobe;
			if (strobe) begin
				meas_latched_q <= meas_data;
			end
		end
	end

	// Pulse arming
	logic          periodic_q;
	logic          pin_en_q;
	logic [NB-1:0] n_q;
	logic [NB-1:0] ncnt_q;
	logic          n_wrap;
	logic          fire;
	assign n_wrap = (n_q == '0) || (ncnt_q == n_q - NB'(1));
	assign fire   = strobe && armed_q && !wr_ctl && (!periodic_q || ncnt_q == '0);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			armed_q    <= 1'b0;
			periodic_q <= 1'b0;
			pin_en_q   <= 1'b0;
			n_q        <= '0;
			ncnt_q     <= '0;
		end else if (wr_ctl) begin
			armed_q    <= 1'b1;
			periodic_q <= host.wdata[upg_pkg::CTL_PER_BIT];
			pin_en_q   <= host.wdata[upg_pkg::CTL_PIN_BIT];
			n_q        <= host.wdata[NB-1:0];
			ncnt_q     <= '0;
		end else if (strobe && armed_q) begin
			if (periodic_q) begin
				ncnt_q <= n_wrap ? '0 : ncnt_q + NB'(1);
			end else begin
				armed_q <= 1'b0;
			end
		end
	end

	// Pulse length counter, independent of the divider
	logic [LB-1:0] plen_q;
	logic [LB-1:0] plen_d;
	logic [LB-1:0] pulse_len;
	assign pulse_len = complex_mode ? LB'(PULSE_CYC_CPLX) : LB'(PULSE_CYC_REAL);
	assign plen_d    = fire ? pulse_len : (plen_q != '0) ? plen_q - LB'(1) : '0;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			plen_q     <= '0;
			timemark_q <= 1'b0;
		end else begin
			plen_q     <= plen_d;
			timemark_q <= plen_d != '0;
		end
	end

	assign timemark_pin = timemark_q && pin_en_q;

	// Checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	logic [LB-1:0] hi_len_q;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			hi_len_q <= '0;
		end else begin
			hi_len_q <= fire ? LB'(1) : timemark_q ? hi_len_q + LB'(1) : '0;
		end
	end

	// A switch to complex mode shortens the step at once, so only a steady real-mode span is timed
	a_tick_real_step: assert property (!complex_mode && tick ##1 !complex_mode [*8] |-> ##[0:1] tick)
		else $error("real mode divider step spacing wrong");
	a_tick_cplx_step: assert property (complex_mode && tick |=> !tick [*7])
		else $error("complex mode divider step too short");
	a_pulse_on_strobe: assert property (fire |-> strobe ##1 timemark_q)
		else $error("pulse not tied to epoch strobe");
	a_pulse_width_ok: assert property ($fell(timemark_q) && $stable(complex_mode)
		|-> $past(hi_len_q) == pulse_len)
		else $error("pulse width differs from length count");
	a_oneshot_disarm: assert property (fire && !periodic_q |=> !armed_q [*2])
		else $error("one-shot stayed armed");
	a_periodic_rearm: assert property (fire && periodic_q && !wr_ctl |=> armed_q && periodic_q)
		else $error("periodic mode lost its arming");
	a_slew_one_period: assert property (strobe && slew_pend_q && !wr_lo |=> !slew_pend_q)
		else $error("slewed ratio outlived one period");
	a_strobe_at_ratio: assert property (strobe |-> cnt_q == ratio - PB'(1) || cnt_q >= ratio)
		else $error("strobe not at divider ratio");
	a_meas_latched: assert property (strobe |=> meas_latched_q == $past(meas_data) && meas_epoch_strobe)
		else $error("measurement not latched at strobe");
	a_pin_gated: assert property (!pin_en_q |-> !timemark_pin)
		else $error("pin driven while disabled");

	// Register writes
	a_hi_latched: assert property (
		wr_hi |=> hi_q == $past(host.wdata[7:0]) && hi_once_q == $past(host.wdata[upg_pkg::HI_ONCE_BIT]))
		else $error("high period half not latched");

	a_period_commit: assert property (
		wr_lo && !hi_once_q |=> period_q == $past(wr_value))
		else $error("persistent period not committed");

	a_slew_loaded: assert property (
		wr_lo && hi_once_q |=> slew_pend_q && slew_q == $past(wr_value))
		else $error("one-period ratio not loaded");

	a_slew_holds: assert property (
		slew_pend_q && !strobe |=> slew_pend_q)
		else $error("one-period ratio dropped early");

	a_slew_overrides: assert property (
		slew_pend_q |-> ratio == slew_q)
		else $error("one-period ratio not in use");

	a_unmapped_quiet: assert property (
		host.wr && !wr_hi && !wr_lo && !wr_ctl |=> $stable(hi_q) && $stable(period_q))
		else $error("unmapped write changed the period");

	// Epoch strobe and capture
	a_strobe_on_tick: assert property (
		strobe |-> tick)
		else $error("strobe off a divider step");

	a_epoch_lag: assert property (
		strobe |=> meas_epoch_strobe)
		else $error("epoch strobe output missing");

	a_epoch_single: assert property (
		!strobe |=> !meas_epoch_strobe)
		else $error("epoch strobe output without strobe");

	a_latch_holds: assert property (
		!strobe |=> $stable(meas_latched_q))
		else $error("measurement changed between strobes");

	// Arming
	a_ctl_arms: assert property (
		wr_ctl |=> armed_q && ncnt_q == '0)
		else $error("control write did not arm");

	a_ctl_fields: assert property (
		wr_ctl |=> periodic_q == $past(host.wdata[upg_pkg::CTL_PER_BIT])
			&& pin_en_q == $past(host.wdata[upg_pkg::CTL_PIN_BIT]))
		else $error("control fields not taken");

	a_no_fire_idle: assert property (
		!armed_q |-> !fire)
		else $error("pulse while disarmed");

	a_disarm_stays: assert property (
		!armed_q && !wr_ctl |=> !armed_q)
		else $error("armed without a control write");

	a_modulo_bound: assert property (
		periodic_q && n_q != '0 |-> ncnt_q < n_q)
		else $error("strobe count beyond n");

	// Pulse length
	a_mark_rise_fire: assert property (
		$rose(timemark_q) |-> $past(fire))
		else $error("pulse rose without a strobe");

	a_len_load: assert property (
		fire |=> plen_q == $past(pulse_len))
		else $error("length counter not loaded");

	a_len_down: assert property (
		plen_q != '0 && !fire |=> plen_q == $past(plen_q) - LB'(1))
		else $error("length counter not counting down");

	a_len_idle: assert property (
		plen_q == '0 && !fire |=> plen_q == '0)
		else $error("length counter restarted by itself");

	a_pin_follows: assert property (
		pin_en_q && timemark_q |-> timemark_pin)
		else $error("enabled pin missed the pulse");

	c_oneshot_pulse: cover property (fire && !periodic_q);
	c_periodic_two:  cover property (fire && periodic_q ##[1:1000] fire);
	c_slew_done:     cover property (slew_pend_q && strobe);
	c_pin_pulse:     cover property ($rose(timemark_pin));
	c_cplx_pulse:    cover property (complex_mode && fire);
endmodule // upg_pulse_gen

/* File: upg_pps_sink.sv */
`timescale 1ns/100ps
// Timing receiver: measures each pulse width on the pin in core clock cycles
module upg_pps_sink (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        timemark_pin,
	output logic             width_done,
	output logic [15:0]      width_q
);
	logic        pin_q;
	logic [15:0] cnt_q;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pin_q <= 1'b0;
			cnt_q <= 16'h0000;
			width_done <= 1'b0;
			width_q <= 16'h0000;
		end else begin
			pin_q <= timemark_pin;
			cnt_q <= timemark_pin ? cnt_q + 16'h0001 : 16'h0000;
			width_done <= pin_q & ~timemark_pin;
			if (pin_q & ~timemark_pin) begin
				width_q <= cnt_q;
			end
		end
	end
endmodule // upg_pps_sink

/* File: tb.sv */
`timescale 1ns/100ps
module tb;
	localparam int PLEN = 5;
	logic               core_clk = 1'b0;
	logic               rst = 1'b1;
	upg_pkg::upg_host_s host = '0;
	logic               cplx = 1'b0;
	logic [15:0]        md = 16'h0000;
	logic               stb, tq, tpin, armed, wdone, tq_d, pin_exp;
	logic [15:0]        lat, wval;
	logic [15:0]        exp_q[$];
	int                 n_errors = 0, tests_run = 0, idx = 0, n_mod = 1, c = 0;
	int                 seed = 32'hc94e;

	always #10 core_clk = ~core_clk;

	upg_pulse_gen #(.PULSE_CYC_REAL(PLEN), .PULSE_CYC_CPLX(PLEN), .EPOCH_DEF_REAL(4), .EPOCH_DEF_CPLX(4)) DUT (
		.core_clk(core_clk), .rst(rst), .host(host), .complex_mode(cplx), .meas_data(md),
		.meas_epoch_strobe(stb), .meas_latched_q(lat), .armed_q(armed), .timemark_q(tq), .timemark_pin(tpin));
	upg_pps_sink u_sink (.core_clk(core_clk), .rst(rst), .timemark_pin(tpin), .width_done(wdone), .width_q(wval));

	task automatic check(string what, logic [15:0] e, logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic stop_test;
		$display("Checks %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic wr(logic [9:0] a, logic [15:0] d, logic sm = 1'b0);
		host = '{std_mode: sm, addr: a, wdata: d, wr: 1'b1};
		@(posedge core_clk);
		#1 host.wr = 1'b0;
		@(posedge core_clk);
		#1;
	endtask
	// Leaves c at the cycle count of the last wait
	task automatic strobes(int k);
		repeat (k) begin
			c = 0;
			do begin
				@(posedge core_clk);
				c++;
			end while (stb !== 1'b1 && c < 2000);
		end
		#1;
	endtask
	task automatic rng(int lo, int hi);
		tests_run++;
		if (c < lo || c > hi) begin
			n_errors++;
			$display("Error strobe spacing expected %0d..%0d seen %0d", lo, hi, c);
		end
	endtask
	task automatic gap(int lo, int hi);
		strobes(2);
		rng(lo, hi);
	endtask
	// Starts right after a strobe so the write never meets one
	task automatic ctl(logic per, logic pin, logic [7:0] n, int pulses);
		strobes(1);
		md = 16'($random(seed));
		n_mod = (n == 8'h00) ? 1 : int'(n);
		pin_exp = pin;
		idx = 0;
		repeat (pulses) exp_q.push_back(16'(PLEN));
		wr(upg_pkg::OFS_PULSE_CTL, {per, pin, 6'h00, n});
	endtask

	always @(posedge core_clk) begin
		tq_d <= tq;
		if (!rst && stb === 1'b1) begin
			check("latched data", md, lat);
			idx <= idx + 1;
		end
		if (!rst && tq === 1'b1 && tq_d === 1'b0) begin
			check("strobe at pulse start", 16'h0001, {15'h0, stb});
			check("strobe index", 16'h0000, 16'(idx % n_mod));
			check("pin enable", {15'h0, pin_exp}, {15'h0, tpin});
		end
		if (wdone === 1'b1) begin
			if (exp_q.size() == 0)
				check("unexpected pulse", 16'h0000, wval);
			else
				check("pulse width", exp_q.pop_front(), wval);
		end
	end

	initial begin
		#400000;
		n_errors++;
		$display("Error watchdog expected finish seen timeout");
		stop_test();
	end

	initial begin
		repeat (10) @(posedge core_clk);
		#1 rst = 1'b0;
		gap(34, 36);
		ctl(1'b0, 1'b1, 8'h05, 1);
		strobes(4);
		check("armed after single", 16'h0000, {15'h0, armed});
		$display("Done: single pulse");
		ctl(1'b1, 1'b1, 8'(2 + $unsigned($random(seed)) % 3), 3);
		strobes(3 * n_mod - 1);
		check("armed in periodic", 16'h0001, {15'h0, armed});
		ctl(1'b1, 1'b0, 8'h01, 0);
		strobes(3);
		ctl(1'b0, 1'b0, 8'h00, 0);
		strobes(3);
		$display("Done: periodic pulses");
		cplx = 1'b1;
		gap(33, 35);
		ctl(1'b0, 1'b1, 8'h00, 1);
		strobes(3);
		cplx = 1'b0;
		$display("Done: complex mode");
		wr(upg_pkg::OFS_PERIOD_HI, 16'h0000);
		wr(10'h1bf, 16'h0003);
		gap(25, 28);
		wr(10'h1b8, 16'h0000);
		gap(25, 28);
		wr(10'h06d, 16'h0000, 1'b1);
		wr(10'h06f, 16'h0002, 1'b1);
		gap(16, 19);
		wr(upg_pkg::OFS_PERIOD_LO, 16'h0003);
		strobes(1);
		wr(upg_pkg::OFS_PERIOD_HI, 16'h8000);
		wr(upg_pkg::OFS_PERIOD_LO, 16'h0001);
		strobes(1);
		rng(0, 12);
		strobes(1);
		gap(25, 28);
		$display("Done: period registers");
		check("pulses missing", 16'h0000, 16'(exp_q.size()));
		stop_test();
	end
endmodule // tb
